// ---- pelc_caps.sv ----
// Capability register bank: AER and ECRC bits, link and slot fields, ECRC
// forwarding flag for the streaming path and completion-buffer overflow.
// Assumes a single AHB-Lite master and synchronous event inputs except the
// overflow and surprise-down pins, which are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module pelc_caps #(
  parameter bit          EN_AER     = 1'b0,
  parameter bit          EN_ECRC_CK = 1'b0,
  parameter bit          EN_ECRC_GN = 1'b0,
  parameter bit          EN_ECRC_FW = 1'b0,
  parameter bit          EN_CPL_TRK = 1'b0,
  parameter bit          ROOT_PORT  = 1'b1,
  parameter bit          EN_DLLA    = 1'b0,
  parameter bit          EN_SDOWN   = 1'b0,
  parameter bit          COMMON_CLK = 1'b0,
  parameter bit          EN_SLOT    = 1'b0,
  parameter logic [12:0] SLOT_NUM   = 13'h0000
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        cpl_buf_ovf_in,
  input  wire logic        surprise_down_in,
  input  wire logic        rx_tlp_sop,
  input  wire logic        rx_tlp_has_ecrc,
  output logic             rx_keep_ecrc,
  output logic             rx_set_td,
  output logic             cpl_buf_ovf,
  output logic             slot_power_msg,
  output logic [7:0]       slot_power_limit,
  output logic [1:0]       slot_power_scale,
  output logic             irq
);
  // Option gating is resolved at build time, so no illegal combination such
  // as ECRC checking without AER can ever reach a register word.
  localparam bit AER_ON  = EN_AER;
  localparam bit CHK_ON  = EN_ECRC_CK & EN_AER;
  localparam bit GEN_ON  = EN_ECRC_GN & EN_AER;
  localparam bit SLOT_ON = EN_SLOT & ROOT_PORT;

  // Every flop of the bank lives in this one record; the next-state logic
  // fills a copy of it and a single clocked process registers that copy.
  typedef struct packed {
    logic                             wr_pend;
    logic                             rd_pend;
    logic [7:0]                       addr;
    logic [31:0]                      rdata;
    logic [1:0]                       ovf_sync;
    logic [1:0]                       sd_sync;
    logic                             ovf;
    logic                             sdown;
    logic                             keep_ecrc;
    logic                             set_td;
    logic                             msg;
    logic [7:0]                       limit;
    logic [1:0]                       scale;
    logic [pelc_pkg::EV_W-1:0]        stat;
    logic [pelc_pkg::EV_W-1:0]        mask;
    logic [7:0]                       msg_count;
  } pelc_state_t;

  pelc_state_t st;
  pelc_state_t next_st;
  logic        take;
  logic [31:0] aer_word;
  logic [31:0] link_word;
  logic [31:0] lstat_word;
  logic [31:0] slot_word;
  logic [pelc_pkg::EV_W-1:0] ev;

  // The bank never stalls, so an address phase is taken at the first edge
  // that sees it and its data phase always lasts exactly one cycle.
  assign take = hsel & hready & (htrans == pelc_pkg::HTRANS_NONSEQ);

  always_comb begin
    aer_word = pelc_pkg::ZERO_WORD;
    aer_word[pelc_pkg::AER_PRESENT_BIT] = AER_ON;
    aer_word[pelc_pkg::ECRC_CHK_BIT] = CHK_ON;
    aer_word[pelc_pkg::ECRC_GEN_BIT] = GEN_ON;
    aer_word[pelc_pkg::ECRC_FWD_BIT] = EN_ECRC_FW;
    link_word = pelc_pkg::ZERO_WORD;
    if (ROOT_PORT) begin
      link_word[pelc_pkg::LINK_PORT_LSB +: 8] = pelc_pkg::PORT_NUMBER;
    end
    link_word[pelc_pkg::LINK_DLLA_BIT] = EN_DLLA & ROOT_PORT;
    link_word[pelc_pkg::LINK_SDOWN_BIT] = EN_SDOWN & ROOT_PORT;
    lstat_word = pelc_pkg::ZERO_WORD;
    lstat_word[pelc_pkg::LSTAT_SLOTCLK] = COMMON_CLK;
    lstat_word[pelc_pkg::LSTAT_SDOWN_BIT] = st.sdown;
    slot_word = pelc_pkg::ZERO_WORD;
    if (SLOT_ON) begin
      slot_word[pelc_pkg::SLOT_PRESENT_BIT] = 1'b1;
      slot_word[pelc_pkg::SLOT_LIMIT_LSB +: 8] = st.limit;
      slot_word[pelc_pkg::SLOT_SCALE_LSB +: 2] = st.scale;
      slot_word[pelc_pkg::SLOT_NUM_LSB +: 13] = SLOT_NUM;
    end
  end

  always_comb begin
    next_st = st;
    next_st.msg = 1'b0;
    // Both status pins are asynchronous; only the second stage of each
    // synchroniser feeds logic, which keeps metastability contained.
    next_st.ovf_sync = {st.ovf_sync[0], cpl_buf_ovf_in};
    next_st.sd_sync = {st.sd_sync[0], surprise_down_in};
    next_st.ovf = EN_CPL_TRK & st.ovf_sync[1];
    next_st.sdown = EN_SDOWN & ROOT_PORT & st.sd_sync[1];
    if (rx_tlp_sop) begin
      next_st.keep_ecrc = EN_ECRC_FW & rx_tlp_has_ecrc;
      next_st.set_td = EN_ECRC_FW & rx_tlp_has_ecrc;
    end
    next_st.wr_pend = take & hwrite;
    next_st.rd_pend = take & ~hwrite;
    if (take) begin
      next_st.addr = haddr[7:0];
    end
    ev = '0;
    ev[pelc_pkg::EV_OVF] = next_st.ovf & ~st.ovf;
    ev[pelc_pkg::EV_SDOWN] = next_st.sdown & ~st.sdown;
    if (st.wr_pend) begin
      if (st.addr == pelc_pkg::ADDR_SLOT_POWER) begin
        if (SLOT_ON) begin
          next_st.limit = hwdata[7:0];
          next_st.scale = hwdata[9:8];
          next_st.msg = 1'b1;
          next_st.msg_count = st.msg_count + 8'h01;
          ev[pelc_pkg::EV_MSG] = 1'b1;
        end
      end else if (st.addr == pelc_pkg::ADDR_IRQ_MASK) begin
        next_st.mask = hwdata[pelc_pkg::EV_W-1:0];
      end
    end
    // Read data is registered at the address phase so that it stands for the
    // whole data phase; it drops to zero afterwards so stale data shows.
    next_st.rdata = pelc_pkg::ZERO_WORD;
    if (take & ~hwrite) begin
      if (haddr[7:0] == pelc_pkg::ADDR_AER_CAP) begin
        next_st.rdata = aer_word;
      end else if (haddr[7:0] == pelc_pkg::ADDR_LINK_CAP) begin
        next_st.rdata = link_word;
      end else if (haddr[7:0] == pelc_pkg::ADDR_LINK_STAT) begin
        next_st.rdata = lstat_word;
      end else if (haddr[7:0] == pelc_pkg::ADDR_SLOT_CAP) begin
        next_st.rdata = slot_word;
      end else if (haddr[7:0] == pelc_pkg::ADDR_SLOT_POWER) begin
        next_st.rdata = SLOT_ON ? {22'h000000, st.scale, st.limit}
                                : pelc_pkg::ZERO_WORD;
      end else if (haddr[7:0] == pelc_pkg::ADDR_IRQ_STAT) begin
        next_st.rdata = {29'h00000000, st.stat};
      end else if (haddr[7:0] == pelc_pkg::ADDR_IRQ_MASK) begin
        next_st.rdata = {29'h00000000, st.mask};
      end else if (haddr[7:0] == pelc_pkg::ADDR_MSG_COUNT) begin
        next_st.rdata = {24'h000000, st.msg_count};
      end
    end
    // Read clears status, but a new event in the same cycle survives.
    if (take & ~hwrite & (haddr[7:0] == pelc_pkg::ADDR_IRQ_STAT)) begin
      next_st.stat = ev;
    end else begin
      next_st.stat = st.stat | ev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.scale <= pelc_pkg::SCALE_RESET;
      st.limit <= pelc_pkg::LIMIT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st.rdata;
  assign rx_keep_ecrc     = st.keep_ecrc;
  assign rx_set_td        = st.set_td;
  assign cpl_buf_ovf      = st.ovf;
  assign slot_power_msg   = st.msg;
  assign slot_power_limit = st.limit;
  assign slot_power_scale = st.scale;
  // The interrupt is a level, high while any unmasked status bit is set.
  assign irq              = |(st.stat & st.mask);

  a_slot_msg_write: assert property (
    @(posedge clk) disable iff (!resetn)
    (st.wr_pend && st.addr == pelc_pkg::ADDR_SLOT_POWER && SLOT_ON)
      |=> slot_power_msg && slot_power_limit == $past(hwdata[7:0]))
    else $error("slot power write did not send message");
  a_msg_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    slot_power_msg |-> $past(st.wr_pend))
    else $error("message without write");
  a_aer_read: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP)
      |=> hrdata[pelc_pkg::AER_PRESENT_BIT] == AER_ON)
    else $error("AER present bit wrong");
  a_ecrc_check: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP)
      |=> hrdata[pelc_pkg::ECRC_CHK_BIT] == (EN_ECRC_CK & EN_AER))
    else $error("ECRC check bit wrong");
  a_ecrc_gen: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP)
      |=> hrdata[pelc_pkg::ECRC_GEN_BIT] == (EN_ECRC_GN & EN_AER))
    else $error("ECRC generation bit wrong");
  a_fwd_td: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_tlp_sop |=> rx_set_td == (EN_ECRC_FW & $past(rx_tlp_has_ecrc)))
    else $error("TD flag wrong");
  a_ovf_follow: assert property (
    @(posedge clk) disable iff (!resetn)
    (EN_CPL_TRK && cpl_buf_ovf_in) [*4] |-> cpl_buf_ovf)
    else $error("overflow not reported");
  a_port_num: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_CAP && ROOT_PORT)
      |=> hrdata[pelc_pkg::LINK_PORT_LSB +: 8] == pelc_pkg::PORT_NUMBER)
    else $error("port number wrong");
  a_slot_clock: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_STAT)
      |=> hrdata[pelc_pkg::LSTAT_SLOTCLK] == COMMON_CLK)
    else $error("slot clock bit wrong");
  a_slot_absent: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_SLOT_CAP && !SLOT_ON)
      |=> hrdata == pelc_pkg::ZERO_WORD)
    else $error("slot register present");
  a_limit_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(st.wr_pend && st.addr == pelc_pkg::ADDR_SLOT_POWER)
      |=> $stable(slot_power_limit) && $stable(slot_power_scale))
    else $error("slot power changed without write");

  // The checks below cover the disabled side of each option except ECRC checking,
  // ECRC generation and the common clock as well, since a build may leave any of them off.
  a_aer_gates_chk: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP)
      |=> !hrdata[pelc_pkg::ECRC_CHK_BIT] || hrdata[pelc_pkg::AER_PRESENT_BIT])
    else $error("ECRC check capable without AER");
  a_aer_gates_gen: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP)
      |=> !hrdata[pelc_pkg::ECRC_GEN_BIT] || hrdata[pelc_pkg::AER_PRESENT_BIT])
    else $error("ECRC generation capable without AER");
  a_aer_absent: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_AER_CAP && !AER_ON)
      |=> !hrdata[pelc_pkg::AER_PRESENT_BIT])
    else $error("AER shown although absent");
  a_keep_value: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_tlp_sop |=> rx_keep_ecrc == (EN_ECRC_FW & $past(rx_tlp_has_ecrc)))
    else $error("ECRC keep flag wrong");
  a_keep_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !rx_tlp_sop |=> $stable(rx_keep_ecrc) && $stable(rx_set_td))
    else $error("forwarding flags changed inside a TLP");
  a_fwd_off: assert property (
    @(posedge clk) disable iff (!resetn)
    !EN_ECRC_FW |-> !rx_keep_ecrc && !rx_set_td)
    else $error("forwarding flags set while forwarding is off");
  a_ovf_off: assert property (
    @(posedge clk) disable iff (!resetn)
    !EN_CPL_TRK |-> !cpl_buf_ovf)
    else $error("overflow shown while tracking is off");
  a_ovf_release: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cpl_buf_ovf_in) [*4] |-> !cpl_buf_ovf)
    else $error("overflow status did not clear");
  a_ovf_event: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(cpl_buf_ovf) |-> st.stat[pelc_pkg::EV_OVF])
    else $error("overflow event not recorded");
  a_sdown_cap: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_CAP)
      |=> hrdata[pelc_pkg::LINK_SDOWN_BIT] == (EN_SDOWN & ROOT_PORT))
    else $error("surprise-down capable bit wrong");
  a_sdown_live: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_STAT)
      |=> hrdata[pelc_pkg::LSTAT_SDOWN_BIT] == $past(st.sdown))
    else $error("surprise-down status bit wrong");
  a_sdown_event: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(st.sdown) |-> st.stat[pelc_pkg::EV_SDOWN])
    else $error("surprise-down event not recorded");
  a_dlla_cap: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_CAP)
      |=> hrdata[pelc_pkg::LINK_DLLA_BIT] == (EN_DLLA & ROOT_PORT))
    else $error("data-link-active reporting bit wrong");
  a_port_absent: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_LINK_CAP && !ROOT_PORT)
      |=> hrdata[pelc_pkg::LINK_PORT_LSB +: 8] == '0)
    else $error("port number shown outside a root port");
  a_scale_field: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_SLOT_CAP && SLOT_ON)
      |=> hrdata[pelc_pkg::SLOT_SCALE_LSB +: 2] == $past(slot_power_scale))
    else $error("slot power scale field wrong");
  a_limit_field: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_SLOT_CAP && SLOT_ON)
      |=> hrdata[pelc_pkg::SLOT_LIMIT_LSB +: 8] == $past(slot_power_limit))
    else $error("slot power limit field wrong");
  a_slot_number: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !hwrite && haddr[7:0] == pelc_pkg::ADDR_SLOT_CAP && SLOT_ON)
      |=> hrdata[pelc_pkg::SLOT_NUM_LSB +: 13] == SLOT_NUM)
    else $error("slot number field wrong");
  a_scale_reset: assert property (
    @(posedge clk)
    $rose(resetn) |-> slot_power_scale == pelc_pkg::SCALE_RESET)
    else $error("slot power scale not zero after reset");
  a_no_slot_msg: assert property (
    @(posedge clk) disable iff (!resetn)
    !SLOT_ON |-> !slot_power_msg)
    else $error("slot power message without a slot");
  a_msg_counted: assert property (
    @(posedge clk) disable iff (!resetn)
    slot_power_msg |-> st.msg_count == $past(st.msg_count) + 8'h01)
    else $error("slot power message not counted");
endmodule : pelc_caps
`default_nettype wire

// ---- pelc_pkg.sv ----
// Constants for the error, link and slot capability register bank.
// Assumes an AHB-Lite master with word accesses and a single slave.
`default_nettype none
package pelc_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_AER_CAP    = 8'h00;
  localparam logic [7:0] ADDR_LINK_CAP   = 8'h04;
  localparam logic [7:0] ADDR_LINK_STAT  = 8'h08;
  localparam logic [7:0] ADDR_SLOT_CAP   = 8'h0C;
  localparam logic [7:0] ADDR_SLOT_POWER = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
  localparam logic [7:0] ADDR_MSG_COUNT  = 8'h1C;
  // Field positions.
  localparam int AER_PRESENT_BIT  = 0;
  localparam int ECRC_GEN_BIT     = 5;
  localparam int ECRC_CHK_BIT     = 7;
  localparam int ECRC_FWD_BIT     = 8;
  localparam int LINK_PORT_LSB    = 24;
  localparam int LINK_SDOWN_BIT   = 19;
  localparam int LINK_DLLA_BIT    = 20;
  localparam int LSTAT_SLOTCLK    = 12;
  localparam int LSTAT_SDOWN_BIT  = 0;
  localparam int SLOT_PRESENT_BIT = 0;
  localparam int SLOT_LIMIT_LSB   = 7;
  localparam int SLOT_SCALE_LSB   = 15;
  localparam int SLOT_NUM_LSB     = 19;
  // Interrupt event bits.
  localparam int EV_MSG   = 0;
  localparam int EV_OVF   = 1;
  localparam int EV_SDOWN = 2;
  localparam int EV_W     = 3;
  // Reset values and fixed values.
  localparam logic [7:0]  PORT_NUMBER   = 8'h01;
  localparam logic [1:0]  SCALE_RESET   = 2'h0;
  localparam logic [7:0]  LIMIT_RESET   = 8'h00;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : pelc_pkg
`default_nettype wire

// ---- pelc_app_model.sv ----
// Application-side stand-in: start-of-TLP pulses with a random ECRC flag.
// Assumes the clock and active-low reset of the capability bank.
`timescale 1ns/1ps
`default_nettype none
module pelc_app_model (
  input  wire logic clk,
  input  wire logic resetn,
  output logic      sop,
  output logic      has_ecrc
);
  logic [1:0] gap;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 2'h0;
      sop <= 1'b0;
      has_ecrc <= 1'b0;
    end else begin
      gap <= gap + 2'h1;
      sop <= (gap == 2'h0);
      // ECRC flag appended.
      // Outside a start pulse the flag is scrambled, so stale use shows.
      has_ecrc <= (gap == 2'h0) ? 1'($urandom) : ~has_ecrc;
    end
  end
endmodule : pelc_app_model
`default_nettype wire

// ---- test_pcie_error_link_slot_caps.sv ----
// Self-checking bench for the capability bank over AHB-Lite.
// Assumes a single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module test_pcie_error_link_slot_caps;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, slot_power_scale;
  logic [2:0] hsize = 3'h2;
  logic ovf_in = 1'b0, sd_in = 1'b0, sop, ecrc, keep, td, ovf, msg, irq;
  logic hreadyout, hresp, rdp = 1'b0, sop_d = 1'b0, ecrc_d = 1'b0;
  logic [7:0] slot_power_limit, lim;
  logic [31:0] rdq[$];
  logic [9:0] msgq[$];
  int error_cnt = 0, comparisons = 0;
  always #2 clk = ~clk;
  // Five options are raised and the rest keep their defaults, so both
  // settings of the capability bits are seen in one run.
  pelc_caps #(.EN_AER(1'b1), .EN_ECRC_FW(1'b1), .EN_CPL_TRK(1'b1),
    .EN_SDOWN(1'b1), .EN_SLOT(1'b1)) dut_u (.clk(clk), .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cpl_buf_ovf_in(ovf_in),
    .surprise_down_in(sd_in), .rx_tlp_sop(sop), .rx_tlp_has_ecrc(ecrc),
    .rx_keep_ecrc(keep), .rx_set_td(td), .cpl_buf_ovf(ovf),
    .slot_power_msg(msg), .slot_power_limit(slot_power_limit),
    .slot_power_scale(slot_power_scale), .irq(irq));
  pelc_app_model app_u (.clk(clk), .resetn(resetn), .sop(sop),
    .has_ecrc(ecrc));
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pelc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= pelc_pkg::HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Watcher: read data, slot power messages and streaming flags.
  always @(posedge clk) begin
    if (rdp && rdq.size() > 0) chk("hrdata", rdq.pop_front(), hrdata);
    rdp = hsel && htrans == pelc_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
    if (msg === 1'b1) begin
      if (msgq.size() == 0) chk("spare msg", 32'h0, 32'h1);
      else chk("power", {22'h0, msgq.pop_front()},
        {22'h0, slot_power_scale, slot_power_limit});
    end
    if (sop_d) chk("keep td", {30'h0, ecrc_d, ecrc_d}, {30'h0, keep, td});
    sop_d = sop === 1'b1 && resetn;
    ecrc_d = ecrc;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hA4A1));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("scale", 32'h0, {30'h0, slot_power_scale});
    rd(pelc_pkg::ADDR_SLOT_POWER, 32'h0);
    bus(1'b1, pelc_pkg::ADDR_AER_CAP, 32'hFFFF_FFFF);
    bus(1'b1, pelc_pkg::ADDR_LINK_CAP, 32'h0);
    rd(pelc_pkg::ADDR_AER_CAP, 32'h0000_0101);
    rd(pelc_pkg::ADDR_LINK_CAP, 32'h0108_0000);
    rd(pelc_pkg::ADDR_LINK_STAT, 32'h0000_0000);
    rd(pelc_pkg::ADDR_SLOT_CAP, 32'h0000_0001);
    rd(8'h20, 32'h0);
    for (int s = 0; s < 4; s++) begin
      lim = (s == 3) ? 8'hFF : 8'($urandom);
      msgq.push_back({2'(s), lim});
      bus(1'b1, pelc_pkg::ADDR_SLOT_POWER, {22'h0, 2'(s), lim});
      rd(pelc_pkg::ADDR_SLOT_POWER, {22'h0, 2'(s), lim});
    end
    rd(pelc_pkg::ADDR_MSG_COUNT, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(pelc_pkg::ADDR_IRQ_STAT, 32'h1);
    bus(1'b1, pelc_pkg::ADDR_IRQ_MASK, 32'h7);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    ovf_in <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ovf", 32'h1, {31'h0, ovf});
    chk("irq", 32'h1, {31'h0, irq});
    rd(pelc_pkg::ADDR_IRQ_STAT, 32'h2);
    @(posedge clk);
    chk("irq read", 32'h0, {31'h0, irq});
    sd_in <= 1'b1;
    repeat (5) @(posedge clk);
    rd(pelc_pkg::ADDR_LINK_STAT, 32'h0000_0001);
    rd(pelc_pkg::ADDR_IRQ_STAT, 32'h4);
    repeat (4) @(posedge clk);
    chk("queues", 32'h0, 32'(rdq.size() + msgq.size()));
    give_verdict();
  end
endmodule : test_pcie_error_link_slot_caps
`default_nettype wire
